// >>> core/vss_defs.svh
// Register offsets, field positions, reset values for the sample setup block
`ifndef VSS_DEFS_SVH
`define VSS_DEFS_SVH

`define VSS_ADDR_W 8
`define VSS_OFF_COLOUR 8'h00
`define VSS_OFF_PULSE 8'h04
`define VSS_OFF_MASK 8'h08
`define VSS_OFF_PWR 8'h0c
`define VSS_OFF_STATUS 8'h10

// Colour / mux control register
`define VSS_COL_LINESEQ 0
`define VSS_COL_ACYC 1
`define VSS_COL_FME 2
`define VSS_COL_CLAMP 3
`define VSS_COL_INTM_LO 4
`define VSS_COL_FM_LO 6
`define VSS_COL_RESET 8'h00

// Sample pulse configuration register
`define VSS_PUL_EN 0
`define VSS_PUL_DEL_LO 1
`define VSS_PUL_POL 4
`define VSS_PUL_RESET 5'h00

// Cell power disable mask and selective power-down control
`define VSS_MASK_RESET 4'h0
`define VSS_PWR_SELECTIVE_POWERDOWN_ON 0
`define VSS_PWR_RESET 1'h0

// Colour field codes
`define VSS_CODE_RED 2'h0
`define VSS_CODE_GREEN 2'h1
`define VSS_CODE_BLUE 2'h2

`define VSS_RESP_OKAY 2'h0
`define VSS_RESP_DECERR 2'h3

`endif

// >>> core/vss_pkg.sv
// Types and decode functions for the sample setup block
`default_nettype none
package vss_pkg;
`include "vss_defs.svh"

  typedef enum logic [0:0] {
    VSS_IDLE = 1'b0,
    VSS_COUNT = 1'b1
  } vss_state_type;

  typedef enum logic [2:0] {
    VSS_SEL_COLOUR = 3'h0,
    VSS_SEL_PULSE = 3'h1,
    VSS_SEL_MASK = 3'h2,
    VSS_SEL_PWR = 3'h3,
    VSS_SEL_STATUS = 3'h4,
    VSS_SEL_NONE = 3'h7
  } vss_reg_type;

  // One-hot red/green/blue select, all zero for the reserved code
  typedef logic [2:0] vss_onehot_type;

  function automatic vss_onehot_type vss_colour_decode(input logic [1:0] c);
    vss_onehot_type r;
    r = 3'h0;
    unique case (c)
      `VSS_CODE_RED: r = 3'h1;
      `VSS_CODE_GREEN: r = 3'h2;
      `VSS_CODE_BLUE: r = 3'h4;
      default: r = 3'h0;
    endcase
    return r;
  endfunction

  function automatic vss_reg_type vss_reg_decode(
    input logic [`VSS_ADDR_W-1:0] a);
    vss_reg_type r;
    r = VSS_SEL_NONE;
    unique case (a)
      `VSS_OFF_COLOUR: r = VSS_SEL_COLOUR;
      `VSS_OFF_PULSE: r = VSS_SEL_PULSE;
      `VSS_OFF_MASK: r = VSS_SEL_MASK;
      `VSS_OFF_PWR: r = VSS_SEL_PWR;
      `VSS_OFF_STATUS: r = VSS_SEL_STATUS;
      default: r = VSS_SEL_NONE;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

// >>> core/vss_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module vss_pin_sync (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic pin_in,
  output logic level_q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end
endmodule // vss_pin_sync
`default_nettype wire

// >>> core/vss_pulse_delay.sv
// Delays an edge strobe by a programmable number of clock periods
`timescale 1ns/10ps
`default_nettype none
module vss_pulse_delay (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic edge_stb,
  input wire logic [2:0] delay,
  output logic pulse_q,
  output logic busy
);
  import vss_pkg::*;

  vss_state_type state_q;
  logic [2:0] cnt_q;

  assign busy = (state_q == VSS_COUNT);

  // A new edge restarts the count, so the last edge always wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= VSS_IDLE;
      cnt_q <= 3'h0;
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= 1'b0;
      if (edge_stb) begin
        if (delay == 3'h0) begin
          pulse_q <= 1'b1;
          state_q <= VSS_IDLE;
        end else begin
          cnt_q <= delay - 3'h1;
          state_q <= VSS_COUNT;
        end
      end else begin
        unique case (state_q)
          VSS_IDLE: begin
          end
          VSS_COUNT: begin
            if (cnt_q == 3'h0) begin
              pulse_q <= 1'b1;
              state_q <= VSS_IDLE;
            end else begin
              cnt_q <= cnt_q - 3'h1;
            end
          end
        endcase
      end
    end
  end
endmodule // vss_pulse_delay
`default_nettype wire

// >>> core/vss_top.sv
// Sample timing conditioning and setup registers behind an AXI4-Lite slave
//
// Overview of operation
// - Internal colour code 00 selects red, 01 green, 10 blue, 11 none.
// - Forced select code 00 routes red, 01 green, 10 blue input, 11 none.
// - Forced mode drives the input mux apart from gain/offset select.
// - With detection off the pin level goes straight to timing control.
// - With detection on an internal pulse replaces the raw pin level.
// - The pulse follows the detected edge by the 3-bit delay in clocks.
// - The delay field has no effect while detection is off.
// - Polarity bit 0 detects falling edges, 1 detects rising edges.
// - The polarity bit has no effect while detection is off.
// - The power-disable mask acts only while selective power-down is 1.
// - An active mask bit at 1 powers its cell down, at 0 leaves it on.
// - Mask bits 0..3 map to red, green, blue cells and the converter.
// - In line mode with auto-cycle select the clamp bit gates clamping.
// - In line mode the force bit picks normal or forced mux selection.
//
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "vss_defs.svh"

module vss_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sample_timing_pin,
  output logic timing_pulse_q,
  output logic [2:0] input_mux_sel_q,
  output logic [2:0] gain_offset_sel_q,
  output logic force_mux_active_q,
  output logic clamp_reg_ctrl_q,
  output logic clamp_active_q,
  output logic [3:0] cell_powerdown_q
);
  import vss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic line_sequential_op_q;
  logic autocycle_or_clamp_sel_q;
  logic force_mux_enable_q;
  logic clamp_enable_bit_q;
  logic [1:0] internal_colour_select_q;
  logic [1:0] forced_input_select_q;
  logic sample_detect_enable_q;
  logic [2:0] pulse_delay_count_q;
  logic edge_polarity_select_q;
  logic [3:0] cell_disable_mask_q;
  logic selective_powerdown_on_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  // Holding flags for a write address or data beat already taken
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic wr_en;
  vss_reg_type wr_sel;
  vss_reg_type rd_sel;
  logic [31:0] rd_word;
  logic pin_level_q;
  logic pin_level_prev_q;
  logic edge_stb;
  logic delayed_pulse_q;
  logic delay_busy;

  // Ready stays low while a response waits: one write and one read in flight
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_en = aw_full_q && w_full_q && !s_axi_bvalid;
  assign wr_sel = vss_reg_decode(awaddr_q);
  // Low address bits are ignored for reads as they are for writes
  assign rd_sel = vss_reg_decode({s_axi_araddr[7:2], 2'b00});

  // Address and data are taken in either order; the write lands once both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (wr_en) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end
    end
  end

  // Unmapped writes are answered DECERR and change no register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `VSS_RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel == VSS_SEL_NONE) ? `VSS_RESP_DECERR
                                              : `VSS_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; only byte lane 0 carries register bits
  // A write with lane 0 strobe low is answered OKAY but stores nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {forced_input_select_q, internal_colour_select_q, clamp_enable_bit_q,
       force_mux_enable_q, autocycle_or_clamp_sel_q,
       line_sequential_op_q} <= `VSS_COL_RESET;
      {edge_polarity_select_q, pulse_delay_count_q,
       sample_detect_enable_q} <= `VSS_PUL_RESET;
      cell_disable_mask_q <= `VSS_MASK_RESET;
      selective_powerdown_on_q <= `VSS_PWR_RESET;
    end else if (wr_en && wstrb0_q) begin
      unique case (wr_sel)
        VSS_SEL_COLOUR: begin
          line_sequential_op_q <= wdata_q[`VSS_COL_LINESEQ];
          autocycle_or_clamp_sel_q <= wdata_q[`VSS_COL_ACYC];
          force_mux_enable_q <= wdata_q[`VSS_COL_FME];
          clamp_enable_bit_q <= wdata_q[`VSS_COL_CLAMP];
          internal_colour_select_q <= wdata_q[`VSS_COL_INTM_LO +: 2];
          forced_input_select_q <= wdata_q[`VSS_COL_FM_LO +: 2];
        end
        VSS_SEL_PULSE: begin
          // Bits 7:5 are not stored and read back as zero
          sample_detect_enable_q <= wdata_q[`VSS_PUL_EN];
          pulse_delay_count_q <= wdata_q[`VSS_PUL_DEL_LO +: 3];
          edge_polarity_select_q <= wdata_q[`VSS_PUL_POL];
        end
        VSS_SEL_MASK: cell_disable_mask_q <= wdata_q[3:0];
        VSS_SEL_PWR: selective_powerdown_on_q <= wdata_q[`VSS_PWR_SELECTIVE_POWERDOWN_ON];
        VSS_SEL_STATUS, VSS_SEL_NONE: begin
        end
      endcase
    end
  end

  // Read data is registered, so the answer comes one cycle after arready
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (rd_sel)
      VSS_SEL_COLOUR:
        rd_word[7:0] = {forced_input_select_q, internal_colour_select_q,
                        clamp_enable_bit_q, force_mux_enable_q,
                        autocycle_or_clamp_sel_q, line_sequential_op_q};
      VSS_SEL_PULSE:
        rd_word[4:0] = {edge_polarity_select_q, pulse_delay_count_q,
                        sample_detect_enable_q};
      VSS_SEL_MASK: rd_word[3:0] = cell_disable_mask_q;
      VSS_SEL_PWR: rd_word[0] = selective_powerdown_on_q;
      VSS_SEL_STATUS:
        rd_word[10:0] = {cell_powerdown_q, clamp_active_q,
                         force_mux_active_q, input_mux_sel_q,
                         delay_busy, pin_level_q};
      VSS_SEL_NONE: rd_word = 32'h0000_0000;
    endcase
  end

  // Unmapped reads return zero data with DECERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `VSS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (rd_sel == VSS_SEL_NONE) ? `VSS_RESP_DECERR
                                              : `VSS_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample timing conditioning

  vss_pin_sync u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(sample_timing_pin),
    .level_q(pin_level_q)
  );

  // Previous level resets low like the idle pin, so reset makes no edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_level_prev_q <= 1'b0;
    end else begin
      pin_level_prev_q <= pin_level_q;
    end
  end

  // Edge strobe only while detection is on; polarity picks the direction
  assign edge_stb = sample_detect_enable_q &&
                    (edge_polarity_select_q ?
                     (pin_level_q && !pin_level_prev_q) :
                     (!pin_level_q && pin_level_prev_q));

  // Delay counter never starts with detection off, so the field is inert
  vss_pulse_delay u_pulse_delay (
    .aclk(aclk),
    .aresetn(aresetn),
    .edge_stb(edge_stb),
    .delay(pulse_delay_count_q),
    .pulse_q(delayed_pulse_q),
    .busy(delay_busy)
  );

  // Turning detection off mid-count drops a pending pulse unless detection is back on before it falls due
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing_pulse_q <= 1'b0;
    end else if (sample_detect_enable_q) begin
      timing_pulse_q <= delayed_pulse_q;
    end else begin
      timing_pulse_q <= pin_level_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Colour selection, clamp and power control

  // Gain and offset always follow the internal code; only the input mux
  // is taken over by the forced select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      force_mux_active_q <= 1'b0;
      input_mux_sel_q <= 3'h0;
      gain_offset_sel_q <= 3'h0;
    end else begin
      force_mux_active_q <= line_sequential_op_q &&
                            force_mux_enable_q;
      gain_offset_sel_q <=
        vss_colour_decode(internal_colour_select_q);
      if (line_sequential_op_q && force_mux_enable_q) begin
        input_mux_sel_q <=
          vss_colour_decode(forced_input_select_q);
      end else begin
        input_mux_sel_q <= vss_colour_decode(internal_colour_select_q);
      end
    end
  end

  // Outside line mode with auto-cycle select, clamping is steered elsewhere
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clamp_reg_ctrl_q <= 1'b0;
      clamp_active_q <= 1'b0;
    end else begin
      clamp_reg_ctrl_q <= line_sequential_op_q && autocycle_or_clamp_sel_q;
      clamp_active_q <= line_sequential_op_q && autocycle_or_clamp_sel_q &&
                        clamp_enable_bit_q;
    end
  end

  // Bit order of the mask is red, green, blue, converter
  // The mask is kept while power-down is off and acts as soon as it is set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cell_powerdown_q <= 4'h0;
    end else if (selective_powerdown_on_q) begin
      cell_powerdown_q <= cell_disable_mask_q;
    end else begin
      cell_powerdown_q <= 4'h0;
    end
  end

endmodule // vss_top
`default_nettype wire

// >>> sim/vss_monitor.sv
// Bus handshake and output consistency checks on vss_top ports
`timescale 1ns/10ps
`default_nettype none
module vss_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timing_pulse_q,
  input wire logic [2:0] input_mux_sel_q,
  input wire logic [2:0] gain_offset_sel_q,
  input wire logic force_mux_active_q,
  input wire logic clamp_reg_ctrl_q,
  input wire logic clamp_active_q
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_gain_onehot: assert property (
    $onehot0(gain_offset_sel_q)) else $error("gain select not one-hot");
  a_mux_onehot: assert property (
    $onehot0(input_mux_sel_q)) else $error("input mux not one-hot");
  a_mux_follows_gain: assert property (
    !force_mux_active_q |-> input_mux_sel_q == gain_offset_sel_q)
    else $error("input mux differs without force");
  a_clamp_gated: assert property (
    clamp_active_q |-> clamp_reg_ctrl_q) else $error("clamp without control");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_pulse: cover property ($rose(timing_pulse_q));
  c_clamp: cover property (clamp_active_q);
endmodule // vss_monitor
bind vss_top vss_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .timing_pulse_q, .input_mux_sel_q, .gain_offset_sel_q,
  .force_mux_active_q, .clamp_reg_ctrl_q, .clamp_active_q);
`default_nettype wire

// >>> sim/vss_host_pin.sv
// Scanner controller model driving the sample timing pin
`timescale 1ns/10ps
`default_nettype none
module vss_host_pin (
  input wire logic aclk,
  output logic pin
);
  initial pin = 1'b0;
  // Changes only right after an edge; callers keep edges well apart
  task automatic drive(input logic v);
    @(posedge aclk);
    pin <= v;
  endtask
endmodule // vss_host_pin
`default_nettype wire

// >>> sim/sample_timing_pin_sync_and_setup_regs_tb_top.sv
// Directed register and pin tests for vss_top
`timescale 1ns/10ps
`default_nettype none
module sample_timing_pin_sync_and_setup_regs_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf, cell_pd;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, pin, pulse;
  logic [2:0] mux_sel, gain_sel;
  logic force_act, clamp_ctrl, clamp_act;
  int failures = 0, checks_done = 0, cycles = 0;
  initial forever #50 aclk = ~aclk;
  vss_host_pin u_host (.aclk(aclk), .pin(pin));
  vss_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_timing_pin(pin), .timing_pulse_q(pulse),
    .input_mux_sel_q(mux_sel), .gain_offset_sel_q(gain_sel),
    .force_mux_active_q(force_act), .clamp_reg_ctrl_q(clamp_ctrl),
    .clamp_active_q(clamp_act), .cell_powerdown_q(cell_pd));
  //////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(bresp, er);
    @(negedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata, e);
    chk(rresp, er);
  endtask
  // Cycles from pin change to the pulse, and how many cycles it stays high
  task automatic meas(input logic v, input int exp_n);
    int n, got, hi;
    got = 0;
    hi = 0;
    u_host.drive(v);
    for (n = 1; n <= 16; n++) begin
      @(posedge aclk);
      #1;
      if (pulse === 1'b1) begin
        hi++;
        if (got == 0) got = n;
      end
    end
    chk(got, exp_n);
    chk(hi, (exp_n != 0) ? 1 : 0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial forever begin
    @(posedge aclk);
    cycles++;
    if (cycles > 5000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    int i, d, p;
    logic [2:0] e;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({cell_pd, mux_sel, gain_sel, clamp_act, pulse}, 32'h0);
    rd(8'h04, 32'h0, 2'h0);
    for (i = 0; i < 4; i++) begin
      e = (i == 3) ? 3'h0 : 3'h1 << i;
      wr(8'h00, i << 4, 2'h0);
      chk(gain_sel, e);
      chk(mux_sel, e);
      wr(8'h00, (i << 6) | 8'h05, 2'h0);
      chk({force_act, gain_sel, mux_sel}, {4'h9, e});
      wr(8'h00, (i << 6) | 8'h04, 2'h0);
      chk({force_act, mux_sel}, 4'h1);
    end
    for (i = 0; i < 16; i++) begin
      wr(8'h00, i, 2'h0);
      chk(clamp_ctrl, i[0] & i[1]);
      chk(clamp_act, i[0] & i[1] & i[3]);
      chk(force_act, i[0] & i[2]);
    end
    rd(8'h00, 32'hf, 2'h0);
    rd(8'h10, 32'h64, 2'h0);
    wr(8'h08, 32'ha, 2'h0);
    chk(cell_pd, 4'h0);
    wr(8'h0c, 32'h1, 2'h0);
    chk(cell_pd, 4'ha);
    wr(8'h08, 32'h5, 2'h0);
    chk(cell_pd, 4'h5);
    wr(8'h0c, 32'h0, 2'h0);
    chk(cell_pd, 4'h0);
    rd(8'h20, 32'h0, 2'h3);
    wr(8'h20, 32'hff, 2'h3);
    @(posedge aclk);
    wstrb <= 4'h0;
    wr(8'h08, 32'hf, 2'h0);
    @(posedge aclk);
    wstrb <= 4'hf;
    rd(8'h08, 32'h5, 2'h0);
    rd(8'h0a, 32'h5, 2'h0);
    // Delay 7 and rising polarity set but detection off
    wr(8'h04, 32'h1e, 2'h0);
    rd(8'h04, 32'h1e, 2'h0);
    // Pass-through lags the pin by five clocks whatever delay is set
    u_host.drive(1'b1);
    repeat (4) @(posedge aclk);
    #1;
    chk(pulse, 1'b0);
    @(posedge aclk);
    #1;
    chk(pulse, 1'b1);
    repeat (8) @(posedge aclk);
    #1;
    chk(pulse, 1'b1);
    u_host.drive(1'b0);
    repeat (4) @(posedge aclk);
    #1;
    chk(pulse, 1'b1);
    @(posedge aclk);
    #1;
    chk(pulse, 1'b0);
    for (p = 0; p < 2; p++) begin
      for (d = 0; d < 8; d += 7) begin
        wr(8'h04, (p << 4) | (d << 1) | 1, 2'h0);
        meas(1'b1, (p == 1) ? 6 + d : 0);
        meas(1'b0, (p == 0) ? 6 + d : 0);
      end
    end
    close_out();
  end
endmodule // sample_timing_pin_sync_and_setup_regs_tb_top
`default_nettype wire
